// >>> shared/scb_consts.svh
// offsets, field positions, reset values and widths of the serial config bank
// assumes inclusion by the package and the bank module only
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH

// ==========================================
// register offsets (15-bit serial address)
`define SCB_ADDR_CFG_A 15'h0000
`define SCB_ADDR_CFG_B 15'h0001
`define SCB_ADDR_PWR 15'h0002
`define SCB_ADDR_CLASS 15'h0003
`define SCB_ADDR_ID_LO 15'h0004
`define SCB_ADDR_ID_HI 15'h0005
`define SCB_ADDR_CHAN_SEL 15'h0008

// ==========================================
// field positions
`define SCB_A_SOFT_RST 0
`define SCB_A_LSB_FIRST 1
`define SCB_A_ASCEND 2
`define SCB_A_ASCEND_M 5
`define SCB_A_LSB_FIRST_M 6
`define SCB_A_SOFT_RST_M 7
`define SCB_B_DP_RST 1
`define SCB_RW_BIT 15

// ==========================================
// reset values and sizes
`define SCB_RST_CHAN_SEL 2'h3
`define SCB_RST_PWR 2'h0
`define SCB_NUM_CH 2
`define SCB_INSTR_LAST 4'hf
`define SCB_BYTE_LAST 4'h7

`endif

// >>> shared/scb_pkg.sv
// types of the serial config bank: phase, pin carriers, state record
// assumes scb_consts.svh on the include path
`default_nettype none
`include "scb_consts.svh"

package scb_pkg;

    // ==========================================
    // frame phase, gray along instruction to data
    typedef enum logic [1:0] {
        PH_INSTR = 2'h0,
        PH_DATA = 2'h1
    } scb_phase_t;

    // serial pins entering the block
    typedef struct packed {
        logic sclk;
        logic portSelectN;
        logic sdioIn;
    } scb_spi_in_t;

    // per-channel datapath controls
    typedef struct packed {
        logic clkEn;
        logic holdReset;
        logic linkEn;
    } scb_chan_ctl_t;

    // all state of the bank
    typedef struct packed {
        scb_phase_t phase;
        logic [3:0] bitCnt;
        logic [15:0] shift;
        logic isRead;
        logic [14:0] addr;
        logic [7:0] txByte;
        logic prevSclk;
        logic sdioOut;
        logic sdioDrive;
        logic lsbFirst;
        logic ascend;
        logic [1:0] chSel;
        logic [`SCB_NUM_CH-1:0][1:0] pwrMode;
        logic dpReset;
    } scb_state_t;

endpackage

`default_nettype wire

// >>> hdl/scb_config_bank.sv
// serial-port configuration register bank with channel power control
// assumes sclk, port_select_n and sdio already synchronous to ref_clk
`include "scb_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module scb_config_bank #(
    parameter int NUM_CH = 2,
    parameter logic [7:0] DEVICE_CLASS = 8'h5a, // arbitrary value
    parameter logic [15:0] IDENT = 16'h1234 // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire scb_pkg::scb_spi_in_t spiIn,
    output logic sdioOut,
    output logic sdioOeN,
    output logic dpResetPulse,
    output scb_pkg::scb_chan_ctl_t [NUM_CH-1:0] chanCtl
);

    // ==========================================
    // elaboration check
    if (NUM_CH != `SCB_NUM_CH) begin : g_bad_ch
        $error("scb_config_bank serves exactly two channels");
    end

    scb_pkg::scb_state_t st;
    scb_pkg::scb_state_t next_st;

    // ==========================================
    // helpers
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    function automatic scb_pkg::scb_state_t rstState();
        scb_pkg::scb_state_t s;
        s = '0;
        s.chSel = `SCB_RST_CHAN_SEL;
        for (int c = 0; c < `SCB_NUM_CH; c++) begin
            s.pwrMode[c] = `SCB_RST_PWR;
        end
        return s;
    endfunction

    // read value of a register address
    function automatic logic [7:0] readMux(input logic [14:0] a, input scb_pkg::scb_state_t s);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            `SCB_ADDR_CFG_A: begin
                r[`SCB_A_LSB_FIRST] = s.lsbFirst;
                r[`SCB_A_LSB_FIRST_M] = s.lsbFirst;
                r[`SCB_A_ASCEND] = s.ascend;
                r[`SCB_A_ASCEND_M] = s.ascend;
            end
            `SCB_ADDR_PWR: r[1:0] = s.chSel[0] ? s.pwrMode[0] : s.pwrMode[1];
            `SCB_ADDR_CLASS: r = DEVICE_CLASS;
            `SCB_ADDR_ID_LO: r = IDENT[7:0];
            `SCB_ADDR_ID_HI: r = IDENT[15:8];
            `SCB_ADDR_CHAN_SEL: r[1:0] = s.chSel;
            default: r = 8'h00; // unmapped and self-clearing read zero
        endcase
        return r;
    endfunction

    // ==========================================
    // serial edges and decoded words
    logic sclkRise;
    logic sclkFall;
    logic [15:0] shiftNext;
    logic [15:0] shiftRev;
    logic [15:0] instrWord;
    logic [7:0] rxByte;
    logic instrDone;
    logic byteDone;
    logic wrEn;
    logic [14:0] addrStep;
    logic softRstHit;

    assign sclkRise = spiIn.sclk & ~st.prevSclk & ~spiIn.portSelectN;
    assign sclkFall = ~spiIn.sclk & st.prevSclk & ~spiIn.portSelectN;
    assign shiftNext = {st.shift[14:0], spiIn.sdioIn};
    // reversed copy, its top byte is the low byte reversed
    assign shiftRev = rev16(shiftNext);
    assign instrWord = st.lsbFirst ? shiftRev : shiftNext;
    assign rxByte = st.lsbFirst ? shiftRev[15:8] : shiftNext[7:0];
    assign instrDone = sclkRise && st.phase == scb_pkg::PH_INSTR && st.bitCnt == `SCB_INSTR_LAST;
    assign byteDone = sclkRise && st.phase == scb_pkg::PH_DATA && st.bitCnt == `SCB_BYTE_LAST;
    assign wrEn = byteDone && !st.isRead;
    assign addrStep = st.ascend ? st.addr + 15'h0001 : st.addr - 15'h0001;
    assign softRstHit = wrEn && st.addr == `SCB_ADDR_CFG_A
        && (rxByte[`SCB_A_SOFT_RST] || rxByte[`SCB_A_SOFT_RST_M]);

    // ==========================================
    // next-state logic
    always_comb begin
        next_st = st;
        next_st.prevSclk = spiIn.sclk;
        next_st.dpReset = 1'b0;
        if (spiIn.portSelectN) begin
            next_st.phase = scb_pkg::PH_INSTR;
            next_st.bitCnt = 4'h0;
            next_st.sdioDrive = 1'b0;
        end else begin
            if (sclkRise) begin
                next_st.shift = shiftNext;
                next_st.bitCnt = st.bitCnt + 4'h1;
            end
            if (instrDone) begin
                next_st.phase = scb_pkg::PH_DATA;
                next_st.bitCnt = 4'h0;
                next_st.isRead = instrWord[`SCB_RW_BIT];
                next_st.addr = instrWord[14:0];
                next_st.txByte = readMux(instrWord[14:0], st);
            end
            if (byteDone) begin
                next_st.bitCnt = 4'h0;
                next_st.addr = addrStep;
                if (st.isRead) begin
                    next_st.txByte = readMux(addrStep, st);
                end
            end
            if (sclkFall && st.phase == scb_pkg::PH_DATA && st.isRead) begin
                next_st.sdioOut = st.lsbFirst ? st.txByte[st.bitCnt[2:0]] : st.txByte[3'h7 - st.bitCnt[2:0]];
                next_st.sdioDrive = 1'b1;
            end
            if (wrEn) begin
                unique case (st.addr)
                    `SCB_ADDR_CFG_A: begin
                        next_st.lsbFirst = rxByte[`SCB_A_LSB_FIRST] | rxByte[`SCB_A_LSB_FIRST_M];
                        next_st.ascend = rxByte[`SCB_A_ASCEND] | rxByte[`SCB_A_ASCEND_M];
                    end
                    `SCB_ADDR_CFG_B: next_st.dpReset = rxByte[`SCB_B_DP_RST];
                    `SCB_ADDR_PWR: begin
                        for (int c = 0; c < `SCB_NUM_CH; c++) begin
                            if (st.chSel[c]) begin
                                next_st.pwrMode[c] = rxByte[1:0];
                            end
                        end
                    end
                    `SCB_ADDR_CHAN_SEL: next_st.chSel = rxByte[1:0];
                    default: next_st.chSel = st.chSel;
                endcase
            end
        end
        // whole bank and serial port back to defaults
        if (softRstHit) begin
            next_st = rstState();
            next_st.prevSclk = spiIn.sclk;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st <= rstState();
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // outputs
    assign sdioOut = st.sdioOut;
    assign sdioOeN = ~st.sdioDrive; // low while driving
    assign dpResetPulse = st.dpReset;

    // per-channel power decode
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        assign chanCtl[c].clkEn = ~st.pwrMode[c][1];
        assign chanCtl[c].holdReset = st.pwrMode[c] == 2'h3;
        assign chanCtl[c].linkEn = st.pwrMode[c] != 2'h3;
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_soft_reset;
        softRstHit
        |=> st.pwrMode == '0 && !st.lsbFirst && !st.ascend && st.chSel == 2'h3 && st.phase == scb_pkg::PH_INSTR;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");

    property p_mirror;
        wrEn && st.addr == `SCB_ADDR_CFG_A && rxByte == 8'h60 |=> st.lsbFirst && st.ascend
        ##1 readMux(`SCB_ADDR_CFG_A, st) == 8'h66;
    endproperty
    a_mirror: assert property (p_mirror) else $error("order and direction mirrors failed");

    property p_lsb_out;
        sclkFall && st.phase == scb_pkg::PH_DATA && st.isRead && st.lsbFirst && st.bitCnt == 4'h0
        |=> sdioOut == $past(st.txByte[0]) && !sdioOeN;
    endproperty
    a_lsb_out: assert property (p_lsb_out) else $error("lsb first bit wrong");

    property p_addr_step;
        byteDone && !softRstHit |=> st.addr == ($past(st.ascend) ? $past(st.addr) + 15'h1 : $past(st.addr) - 15'h1);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step wrong");

    property p_dp_reset;
        wrEn && st.addr == `SCB_ADDR_CFG_B && rxByte[`SCB_B_DP_RST] |=> dpResetPulse ##1 !dpResetPulse;
    endproperty
    a_dp_reset: assert property (p_dp_reset) else $error("datapath reset not one pulse");

    property p_power_up;
        $fell(sys_rst) |-> chanCtl[0].clkEn && chanCtl[1].clkEn && chanCtl[0].linkEn && !chanCtl[1].holdReset;
    endproperty
    a_power_up: assert property (p_power_up) else $error("not normal after reset");

    property p_standby;
        st.pwrMode[0] == 2'h2 |-> !chanCtl[0].clkEn && chanCtl[0].linkEn && !chanCtl[0].holdReset;
    endproperty
    a_standby: assert property (p_standby) else $error("standby decode wrong");

    property p_power_down;
        st.pwrMode[1] == 2'h3 |-> !chanCtl[1].clkEn && !chanCtl[1].linkEn && chanCtl[1].holdReset;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down decode wrong");

    property p_read_only;
        wrEn && (st.addr inside {`SCB_ADDR_CLASS, `SCB_ADDR_ID_LO, `SCB_ADDR_ID_HI})
        |=> st.pwrMode == $past(st.pwrMode) && st.chSel == $past(st.chSel) && st.lsbFirst == $past(st.lsbFirst)
            && st.ascend == $past(st.ascend) && !dpResetPulse;
    endproperty
    a_read_only: assert property (p_read_only) else $error("write to read-only register changed state");

    property p_both_write;
        wrEn && st.addr == `SCB_ADDR_PWR && st.chSel == 2'h3 && !softRstHit
        |=> st.pwrMode[0] == $past(rxByte[1:0]) && st.pwrMode[1] == $past(rxByte[1:0]);
    endproperty
    a_both_write: assert property (p_both_write) else $error("dual channel write missed");

    property p_both_read;
        instrDone && instrWord[`SCB_RW_BIT] && instrWord[14:0] == `SCB_ADDR_PWR && st.chSel == 2'h3
        |=> st.txByte == {6'h00, $past(st.pwrMode[0])};
    endproperty
    a_both_read: assert property (p_both_read) else $error("dual read not first channel");

    c_soft_reset: cover property (softRstHit);
    c_read_byte: cover property (byteDone && st.isRead);
    c_power_down: cover property (st.pwrMode[0] == 2'h3);
    c_lsb_write: cover property (wrEn && st.lsbFirst);

endmodule

`default_nettype wire

// >>> tb/scb_spi_host.sv
// serial host model driving the config bank's select, clock and data pins
// assumes ref_clk from the bench and the bank's split sdio pins
`timescale 1ns/1ns
`default_nettype none

module scb_spi_host (
    input wire logic ref_clk,
    input wire logic sdioOut,
    input wire logic sdioOeN,
    output var scb_pkg::scb_spi_in_t spiIn
);
    logic sclk = 1'b0;
    logic sel = 1'b1;
    logic dout = 1'b0;

    // ==========================================
    // shared data wire: device level while it drives
    assign spiIn = '{sclk: sclk, portSelectN: sel, sdioIn: sdioOeN ? dout : sdioOut};

    // one serial bit: data set with clock low, sampled at the rise
    task automatic bit_io(input logic b, output logic r);
        sclk <= 1'b0;
        dout <= b;
        repeat (3) @(posedge ref_clk);
        sclk <= 1'b1;
        // an undriven line reads as the inverse of the stale level
        r = sdioOeN ? ~sdioOut : sdioOut;
        repeat (3) @(posedge ref_clk);
    endtask

    // whole frame: 16-bit instruction then n bytes, byte 0 in wd[7:0]
    // bench writes only documented addresses, the read-only identity addresses included
    task automatic frame(input logic lsb, input logic [15:0] instr, input int n, input logic [31:0] wd,
                         output logic [31:0] rd);
        int i;
        int j;
        logic r;
        rd = 32'h0;
        @(posedge ref_clk);
        sel <= 1'b0;
        for (i = 0; i < 16; i++) begin
            bit_io(instr[lsb ? i : 15 - i], r);
        end
        for (i = 0; i < n * 8; i++) begin
            j = (i / 8) * 8 + (lsb ? i % 8 : 7 - i % 8);
            // released line toggles so a stale level never passes
            bit_io(instr[15] ? ~dout : wd[j], r);
            rd[j] = r;
        end
        sclk <= 1'b0;
        repeat (3) @(posedge ref_clk);
        sel <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // idle span after a soft reset
    task automatic boot_wait(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
// self-checking bench of the serial config bank
// assumes scb_spi_host as the far side and the design defaults of its parameters
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam logic [7:0] CLASS = 8'h5a; // arbitrary value
    localparam logic [15:0] IDENT = 16'h1234; // arbitrary value
    localparam int BOOT_WAIT = 50000; // 5 ms of 100 ns cycles
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    scb_pkg::scb_spi_in_t spiIn;
    logic sdioOut;
    logic sdioOeN;
    logic dpResetPulse;
    scb_pkg::scb_chan_ctl_t [1:0] chanCtl;
    int errors = 0;
    int checked = 0;
    int pulses = 0;
    int i;
    logic [31:0] rd;
    logic [7:0] rstVal [3] = '{8'h81, 8'h80, 8'h01};

    // ==========================================
    // clock, units under test
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    scb_config_bank u_scb_config_bank (.ref_clk(ref_clk), .sys_rst(sys_rst), .spiIn(spiIn),
        .sdioOut(sdioOut), .sdioOeN(sdioOeN), .dpResetPulse(dpResetPulse), .chanCtl(chanCtl));
    scb_spi_host u_scb_spi_host (.ref_clk(ref_clk), .sdioOut(sdioOut), .sdioOeN(sdioOeN), .spiIn(spiIn));

    // counts cycles of datapath reset
    always @(posedge ref_clk) begin
        if (dpResetPulse === 1'b1) pulses <= pulses + 1;
    end

    // ==========================================
    // compare, access and verdict tasks
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_ctl(input logic [5:0] got, input logic [5:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected channel controls at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic lsb, input logic [14:0] a, input logic [7:0] d);
        logic [31:0] r;
        u_scb_spi_host.frame(lsb, {1'b0, a}, 1, {24'h0, d}, r);
    endtask

    task automatic rdv(input logic lsb, input logic [14:0] a, input int n, output logic [31:0] r);
        u_scb_spi_host.frame(lsb, {1'b1, a}, n, 32'h0, r);
    endtask

    // {clkEn, holdReset, linkEn} expected for a power mode
    function automatic logic [2:0] ctl_of(input logic [1:0] m);
        return (m == 2'h3) ? 3'h2 : ((m == 2'h2) ? 3'h1 : 3'h5);
    endfunction

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung frame
    initial begin
        repeat (120000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end

    // ==========================================
    // test sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        // defaults, identity, unmapped read
        rdv(1'b0, 15'h0000, 1, rd);
        cmp_byte(rd[7:0], 8'h00);
        rdv(1'b0, 15'h0002, 1, rd);
        cmp_byte(rd[7:0], 8'h00);
        rdv(1'b0, 15'h0008, 1, rd);
        cmp_byte(rd[7:0], 8'h03);
        rdv(1'b0, 15'h0007, 1, rd);
        cmp_byte(rd[7:0], 8'h00);
        cmp_ctl(chanCtl, {ctl_of(2'h0), ctl_of(2'h0)});
        cmp_byte({7'h0, sdioOeN}, 8'h01);
        for (i = 0; i < 2; i++) begin
            rdv(1'b0, 15'h0005, 3, rd);
            cmp_byte(rd[7:0], IDENT[15:8]);
            cmp_byte(rd[15:8], IDENT[7:0]);
            cmp_byte(rd[23:16], CLASS);
            u_scb_spi_host.frame(1'b0, 16'h0005, 3, 32'h00a5c3e1, rd);
        end
        $display("test identity done");
        // every power mode on both channels
        for (i = 0; i < 4; i++) begin
            wr(1'b0, 15'h0002, i[7:0]);
            cmp_ctl(chanCtl, {ctl_of(i[1:0]), ctl_of(i[1:0])});
        end
        wr(1'b0, 15'h0008, 8'h01);
        wr(1'b0, 15'h0002, 8'h00);
        cmp_ctl(chanCtl, {ctl_of(2'h3), ctl_of(2'h0)});
        wr(1'b0, 15'h0008, 8'h03);
        rdv(1'b0, 15'h0002, 1, rd);
        cmp_byte(rd[7:0], 8'h00);
        wr(1'b0, 15'h0008, 8'h02);
        rdv(1'b0, 15'h0002, 1, rd);
        cmp_byte(rd[7:0], 8'h03);
        wr(1'b0, 15'h0008, 8'h03);
        $display("test power modes done");
        // datapath reset pulse and self-clear
        wr(1'b0, 15'h0001, 8'h02);
        repeat (4) @(posedge ref_clk);
        cmp_byte(pulses[7:0], 8'h01);
        wr(1'b0, 15'h0001, 8'h00);
        rdv(1'b0, 15'h0001, 1, rd);
        cmp_byte(rd[7:0], 8'h00);
        cmp_byte(pulses[7:0], 8'h01);
        $display("test datapath reset done");
        // mirrors set order and direction, then lsb-first ascending read
        wr(1'b0, 15'h0000, 8'h60);
        rdv(1'b1, 15'h0000, 1, rd);
        cmp_byte(rd[7:0], 8'h66);
        rdv(1'b1, 15'h0003, 3, rd);
        cmp_byte(rd[7:0], CLASS);
        cmp_byte(rd[15:8], IDENT[7:0]);
        cmp_byte(rd[23:16], IDENT[15:8]);
        $display("test order and direction done");
        // soft reset by both bits, the mirror and the primary
        for (i = 0; i < 3; i++) begin
            wr(i == 0, 15'h0008, 8'h01);
            wr(i == 0, 15'h0002, 8'h03);
            wr(i == 0, 15'h0000, rstVal[i]);
            cmp_ctl(chanCtl, {ctl_of(2'h0), ctl_of(2'h0)});
            rdv(1'b0, 15'h0000, 1, rd);
            cmp_byte(rd[7:0], 8'h00);
            rdv(1'b0, 15'h0008, 1, rd);
            cmp_byte(rd[7:0], 8'h03);
            // only reads until boot loading is over, then the next writes
            if (i < 2) begin
                u_scb_spi_host.boot_wait(BOOT_WAIT);
            end
        end
        $display("test soft reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
